// ===== rtl/ipg_gate.sv
// Interrupt pacing gate: merges level requests into one paced CPU line.
// Assumes sources are synchronous to pclk; pclk is the peripheral clock,
// i.e. the CPU clock divided by six, so one decrement per pclk edge.
module ipg_gate #(
  parameter int NUM_SRC = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipg_pkg::IPG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources and outputs
  input wire logic [NUM_SRC-1:0] src_irq,
  output logic combined_irq_out,
  output logic event_irq
);
  import ipg_pkg::*;

  logic combined_irq_enable_bit_q;
  logic [IPG_CNT_W-1:0] interrupt_pacing_reload_q;
  logic [IPG_CNT_W-1:0] hold_cnt_q, hold_cnt_d;
  logic [1:0] evt_status_q, evt_status_d, evt_mask_q;
  logic [31:0] prdata_q;
  logic irq_q;

  // Bus decode; slave answers in the access cycle, no wait states
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_ctrl = (paddr == IPG_OFF_CTRL);
  wire hit_rel = (paddr == IPG_OFF_RELOAD);
  wire hit_sts = (paddr == IPG_OFF_STATUS);
  wire hit_msk = (paddr == IPG_OFF_MASK);
  wire hit_cnt = (paddr == IPG_OFF_COUNT);
  wire mapped = hit_ctrl | hit_rel | hit_sts | hit_msk | hit_cnt;
  wire en_wr = wr & hit_ctrl;
  wire en_new = pwdata[IPG_EN_BIT];
  wire en_rise = en_wr & en_new & ~combined_irq_enable_bit_q;
  wire any_src = |src_irq;
  wire out_next;
  wire [1:0] evt_set;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // reload register write, 17 bits kept
  // full 17-bit range up to max
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_pacing_reload_q <= IPG_RELOAD_RST;
    end else if (wr & hit_rel) begin
      interrupt_pacing_reload_q <= pwdata[IPG_CNT_W-1:0] & IPG_RELOAD_MAX;
    end
  end

  // Enable bit storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      combined_irq_enable_bit_q <= 1'b0;
    end else if (en_wr) begin
      combined_irq_enable_bit_q <= en_new;
    end
  end

  // one decrement per pclk, the CPU-over-six tick
  always_comb begin
    hold_cnt_d = hold_cnt_q;
    if (en_rise) begin
      hold_cnt_d = interrupt_pacing_reload_q;
    end else if (hold_cnt_q != '0) begin
      hold_cnt_d = hold_cnt_q - IPG_CNT_W'(IPG_DEC_CYCLES);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= '0;
    end else begin
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // Output gating. The registered output looks one cycle ahead, so a
  // reloading write blocks the line as the count is loaded.
  // non-zero count blocks
  // assert on source, enable and zero count
  // reloaded non-zero count blocks at once
  assign out_next = any_src & (en_wr ? en_new : combined_irq_enable_bit_q)
                    & (hold_cnt_d == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= out_next;
    end
  end
  // line re-rises after re-enable with pending source
  assign combined_irq_out = irq_q;

  // Sticky events: bit0 line asserted, bit1 reload happened.
  // Set wins over a write-one clear in the same cycle.
  assign evt_set = {en_rise, out_next & ~irq_q};
  always_comb begin
    evt_status_d = evt_status_q;
    if (wr & hit_sts) begin
      evt_status_d = evt_status_q & ~pwdata[1:0];
    end
    evt_status_d = evt_status_d | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_q <= IPG_EVT_RST;
      evt_mask_q <= IPG_EVT_RST;
    end else begin
      evt_status_q <= evt_status_d;
      if (wr & hit_msk) begin
        evt_mask_q <= pwdata[1:0];
      end
    end
  end
  assign event_irq = |(evt_status_q & evt_mask_q);

  // Read data captured at the setup phase edge; unmapped reads zero
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0, combined_irq_enable_bit_q} :
    hit_rel ? {15'h0, interrupt_pacing_reload_q} :
    hit_sts ? {30'h0, evt_status_q} :
    hit_msk ? {30'h0, evt_mask_q} :
    hit_cnt ? {15'h0, hold_cnt_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // Assertions. All but the reset check are switched off during reset,
  // so the first edge after release sees only settled reset values.
  // Reload loads count
  reload_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_rise |=> hold_cnt_q == $past(interrupt_pacing_reload_q))
    else $error("count not reloaded on enable rise");

  // No reload on second write of one
  no_reload_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (en_wr & combined_irq_enable_bit_q & hold_cnt_q == '0) |=>
    hold_cnt_q == '0)
    else $error("count reloaded without enable rise");
  // Counting down
  count_down_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!en_rise && hold_cnt_q != '0) |=> hold_cnt_q == $past(hold_cnt_q) - 1)
    else $error("count did not decrement");

  // Stays at zero
  zero_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!en_rise && hold_cnt_q == '0) |=> hold_cnt_q == '0)
    else $error("count left zero without reload");

  // Blocked while counting
  hold_block_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    hold_cnt_q != '0 |-> !combined_irq_out)
    else $error("output high during holdoff");

  // Asserted when allowed
  irq_assert_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (any_src && combined_irq_enable_bit_q && hold_cnt_q == '0 && !en_wr)
    |=> $past(hold_cnt_d) != '0 || combined_irq_out)
    else $error("output not asserted");
  // Enable off holds low
  en_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !combined_irq_enable_bit_q |-> !combined_irq_out)
    else $error("output high while disabled");

  // Reload blocks at once; a count of one may end on the next edge,
  // so only the first cycle after the load is checked here
  reload_block_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (en_rise && interrupt_pacing_reload_q != '0) |=>
    (!combined_irq_out && hold_cnt_q != '0))
    else $error("output slipped through on reload");

  // Reserved reload bits read zero
  reload_rsvd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_rel) |=> prdata[31:17] == '0)
    else $error("reserved reload bits not zero");

  // Any 17-bit value lands, up to the largest
  reload_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_rel) |=>
    {15'h0, interrupt_pacing_reload_q} == ($past(pwdata) & 32'h0001FFFF))
    else $error("reload write not kept");
  // Reload value is zero in reset
  reload_rst_a: assert property (
    @(posedge pclk)
    !presetn |-> interrupt_pacing_reload_q == IPG_RELOAD_RST)
    else $error("reload not cleared by reset");

  // Zero reload leaves pacing inactive
  zero_reload_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (en_rise && interrupt_pacing_reload_q == '0) |=> hold_cnt_q == '0)
    else $error("zero reload started a holdoff");

  // Pending source re-raises the line on re-enable with a zero reload
  refire_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (en_rise && any_src && interrupt_pacing_reload_q == '0) |=>
    combined_irq_out)
    else $error("pending source not re-asserted");
  // No source, no output
  no_src_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !any_src |=> !combined_irq_out)
    else $error("output high without a source");

  // Disabling write drops the line at once
  dis_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (en_wr && !en_new) |=> !combined_irq_out)
    else $error("output not dropped on disable");

  // Holdoff span checker. Counts edges since the last reloading enable
  // and keeps what was loaded; one bit wider than the count so it cannot
  // wrap within the longest holdoff, and it saturates after that.
  logic [IPG_CNT_W:0] since_load_q;
  logic [IPG_CNT_W-1:0] load_val_q;
  logic armed_q;
  wire since_full = &since_load_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_load_q <= '0;
      load_val_q <= '0;
      armed_q <= 1'b0;
    end else if (en_rise) begin
      since_load_q <= '0;
      load_val_q <= interrupt_pacing_reload_q;
      armed_q <= 1'b1;
    end else if (!since_full) begin
      since_load_q <= since_load_q + 1'b1;
    end
  end

  // Line cannot rise before the loaded count has run out
  hold_span_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (armed_q && $rose(combined_irq_out)) |->
    since_load_q >= {1'b0, load_val_q})
    else $error("output rose inside holdoff");
  // Exactly one decrement per pclk tick after a load
  hold_rate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (armed_q && since_load_q <= {1'b0, load_val_q}) |->
    hold_cnt_q == load_val_q - since_load_q[IPG_CNT_W-1:0])
    else $error("holdoff rate wrong");
  // Event sets always land, even against a clear
  evt_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|evt_set) |=> (evt_status_q & $past(evt_set)) == $past(evt_set))
    else $error("status event lost");

  // Write-one clears status bits
  evt_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_sts && evt_set == 2'h0) |=>
    ({30'h0, evt_status_q} & $past(pwdata)) == 32'h0)
    else $error("status bit not cleared");
  // Unmapped writes change nothing
  bad_addr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && !mapped) |=>
    ($stable(interrupt_pacing_reload_q) && $stable(evt_mask_q)))
    else $error("unmapped write took effect");
  // Live count ignores writes
  count_ro_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_cnt && hold_cnt_q == '0) |=> hold_cnt_q == '0)
    else $error("count register was written");
endmodule

// ===== rtl/ipg_pkg.sv
// Package for the interrupt pacing gate: register map, field layout, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
package ipg_pkg;
  localparam int IPG_ADDR_W = 8;
  localparam int IPG_CNT_W = 17;
  // Register byte offsets
  localparam logic [7:0] IPG_OFF_CTRL = 8'h04;
  localparam logic [7:0] IPG_OFF_RELOAD = 8'h08;
  localparam logic [7:0] IPG_OFF_STATUS = 8'h0C;
  localparam logic [7:0] IPG_OFF_MASK = 8'h10;
  localparam logic [7:0] IPG_OFF_COUNT = 8'h14;
  // Field positions
  localparam int IPG_EN_BIT = 0;
  // Values after reset, and the reload field maximum
  localparam logic [16:0] IPG_RELOAD_RST = 17'h00000;
  localparam logic [16:0] IPG_RELOAD_MAX = 17'h1FFFF;
  localparam logic [1:0] IPG_EVT_RST = 2'h0;
  // Decrement rate: CPU clock divided by this; equal to one pclk tick
  localparam int IPG_CPU_DIV = 6;
  localparam int IPG_DEC_CYCLES = 1;
endpackage

// ===== verification/ipg_cpu_model.sv
// CPU-side model: counts rising edges of the combined interrupt line.
// Assumes the line is synchronous to pclk, as the gate registers it.
module ipg_cpu_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Combined line and the edges recognised on it
  input wire logic irq,
  output int n_edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  // Edge detect: a level held high counts once, like the real CPU
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      n_edges <= 0;
    end else begin
      prev_q <= irq;
      if (irq && !prev_q)
        n_edges <= n_edges + 1;
    end
  end
endmodule

// ===== verification/tb_top.sv
// Testbench: APB tasks drive the pacing gate, CPU model counts edges.
// Assumes a zero-wait APB slave and a 100 ns pclk.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ipg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [IPG_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, evt, err;
  logic [1:0] src = 2'h0;
  int n_fail = 0, n_compared = 0, n_edges;
  // 10 MHz clock
  initial begin
    forever #50 pclk = ~pclk;
  end
  ipg_gate #(.NUM_SRC(2)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_irq(src), .combined_irq_out(irq), .event_irq(evt));
  ipg_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .irq(irq),
    .n_edges(n_edges));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [IPG_ADDR_W-1:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Output is registered, so look 1 ns after the edge
  task automatic irq_at(input int n, input logic exp);
    repeat (n) @(posedge pclk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic complete_run;
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: tests need under a hundred cycles, allow ten thousand
  initial begin
    #1ms;
    n_fail++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, IPG_OFF_RELOAD, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, IPG_OFF_RELOAD, 32'hFFFFFFFF);
    xfer(1'b0, IPG_OFF_RELOAD, 32'h0);
    chk(rd, 32'h0001FFFF);
    src <= 2'h2;
    xfer(1'b1, IPG_OFF_RELOAD, 32'h5);
    xfer(1'b1, IPG_OFF_CTRL, 32'h1);
    irq_at(0, 1'b0);
    irq_at(4, 1'b0);
    irq_at(1, 1'b1);
    xfer(1'b1, IPG_OFF_CTRL, 32'h1);
    irq_at(0, 1'b1);
    xfer(1'b1, IPG_OFF_CTRL, 32'h0);
    irq_at(0, 1'b0);
    // Handler clears source 1 as source 0 goes pending; re-enable with zero reload
    @(posedge pclk);
    src <= 2'h1;
    xfer(1'b1, IPG_OFF_RELOAD, 32'h0);
    xfer(1'b1, IPG_OFF_CTRL, 32'h1);
    irq_at(1, 1'b1);
    chk(n_edges, 32'h2);
    @(posedge pclk);
    src <= 2'h0;
    irq_at(1, 1'b0);
    // Status is sticky, masked onto event_irq, cleared by writing ones
    xfer(1'b1, IPG_OFF_MASK, 32'h1);
    xfer(1'b0, IPG_OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk({31'h0, evt}, 32'h1);
    xfer(1'b1, IPG_OFF_STATUS, 32'h3);
    xfer(1'b0, IPG_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, evt}, 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Live count read two edges into a holdoff of seven
    xfer(1'b1, IPG_OFF_RELOAD, 32'h7);
    xfer(1'b1, IPG_OFF_CTRL, 32'h0);
    xfer(1'b1, IPG_OFF_CTRL, 32'h1);
    xfer(1'b0, IPG_OFF_COUNT, 32'h0);
    chk(rd, 32'h6);
    // Reload event routed through mask bit 1
    xfer(1'b1, IPG_OFF_MASK, 32'h2);
    xfer(1'b0, IPG_OFF_STATUS, 32'h0);
    chk(rd, 32'h2);
    chk({31'h0, evt}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    complete_run();
  end
endmodule
